// *** src/ulmsc_consts.svh ***
// Register offsets, field positions, reset values and counts for the line/modem status block
`ifndef ULMSC_CONSTS_SVH
`define ULMSC_CONSTS_SVH

`define ULMSC_ADDR_W           3
`define ULMSC_OFF_MODEM_CTRL   3'h4
`define ULMSC_OFF_LINE_STATUS  3'h5
`define ULMSC_OFF_MODEM_STATUS 3'h6
`define ULMSC_OFF_RS485_SETUP  3'h7

`define ULMSC_MCR_DTR          0
`define ULMSC_MCR_RTS          1
`define ULMSC_MCR_OP1          2
`define ULMSC_MCR_OP2          3
`define ULMSC_MCR_XON_ANY      5
`define ULMSC_MCR_IR_EN        6
`define ULMSC_MCR_PRESCALE     7
`define ULMSC_MCR_ENH_MASK     8'he0

`define ULMSC_MCR_RESET        8'h00
`define ULMSC_SHR_RESET        8'h00
`define ULMSC_PRESCALE_DIV     3'h4
`define ULMSC_FRAME_BITS       10

`endif

// *** src/ulmsc_pkg.sv ***
// Types shared by the line/modem status block
package ulmsc_pkg;

	// Automatic RS-485 direction sequencer states
	typedef enum logic [1:0] {
		R485_IDLE  = 2'b00,
		R485_SETUP = 2'b01,
		R485_SEND  = 2'b10,
		R485_HOLD  = 2'b11
	} ulmsc_r485_state_t;

	// Modem inputs as active-high levels
	typedef struct packed {
		logic cd;
		logic ri;
		logic dsr;
		logic cts;
	} ulmsc_modem_t;

	// One completed receive character from the receiver
	typedef struct packed {
		logic valid;
		logic flow_char;
		logic parity_err;
		logic frame_err;
	} ulmsc_rx_evt_t;

endpackage

// *** src/ulmsc_rs485.sv ***
// Automatic RS-485 direction control with setup and turn-around delays
`timescale 1ns/100ps
`include "ulmsc_consts.svh"
module ulmsc_rs485 import ulmsc_pkg::*; (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Control
	input  wire logic       enable,
	input  wire logic       bit_tick,
	input  wire logic [3:0] setup_bits,
	input  wire logic [3:0] hold_bits,
	// Transmitter handshake
	input  wire logic       tx_pending,
	input  wire logic       tx_busy,
	output logic            rts_active,
	output logic            tx_go
);
	ulmsc_r485_state_t state_reg, state_next;
	logic [3:0]        cnt_reg, cnt_next;
	wire               last_tick = bit_tick && (cnt_reg == 4'h1);
	wire               tx_done   = !tx_pending && !tx_busy;

	// Next state and bit-time counter
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			R485_IDLE: begin
				if (enable && tx_pending) begin
					cnt_next   = setup_bits;
					state_next = (setup_bits == 4'h0) ? R485_SEND : R485_SETUP;
				end
			end
			R485_SETUP: begin
				if (bit_tick)
					cnt_next = cnt_reg - 4'h1;
				if (last_tick)
					state_next = R485_SEND;
			end
			R485_SEND: begin
				if (tx_done) begin
					cnt_next   = hold_bits;
					state_next = (hold_bits == 4'h0) ? R485_IDLE : R485_HOLD;
				end
			end
			R485_HOLD: begin
				if (bit_tick)
					cnt_next = cnt_reg - 4'h1;
				if (tx_pending)
					state_next = R485_SEND;
				else if (last_tick)
					state_next = R485_IDLE;
			end
		endcase
		if (!enable)
			state_next = R485_IDLE;
	end

	// State registers and registered outputs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg  <= R485_IDLE;
			cnt_reg    <= 4'h0;
			rts_active <= 1'b0;
			tx_go      <= 1'b0;
		end else begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			rts_active <= (state_next != R485_IDLE);
			tx_go      <= (state_next == R485_SEND);
		end
	end
endmodule

// *** src/ulmsc_top.sv ***
// Line status, modem status, modem control extension and RS-485 control of a serial port
`timescale 1ns/100ps
`include "ulmsc_consts.svh"
module ulmsc_top import ulmsc_pkg::*; #(
	parameter int FRAME_BITS = `ULMSC_FRAME_BITS,
	parameter int FIFO_DEPTH = 128
) (
	// Clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	// Host register port
	input  wire logic [`ULMSC_ADDR_W-1:0] host_addr,
	input  wire logic                     host_wr,
	input  wire logic                     host_rd,
	input  wire logic [7:0]               host_wdata,
	output logic      [7:0]               host_rdata,
	// Configuration bits held elsewhere
	input  wire logic                     enh_func_en,
	input  wire logic                     loopback_en,
	input  wire logic                     sw_flow_en,
	input  wire logic                     rs485_auto_en,
	input  wire logic                     auto_rts_en,
	input  wire logic                     prog_trig_en,
	input  wire logic                     line_int_en,
	input  wire logic                     modem_int_en,
	// Baud timing
	input  wire logic                     bit_tick,
	output logic                          baud_clk_tick,
	// Receiver side
	input  ulmsc_rx_evt_t                 rx_evt,
	input  wire logic                     rx_fifo_full,
	input  wire logic                     rx_fifo_nonempty,
	input  wire logic                     rx_pop,
	input  wire logic                     rx_pop_err,
	input  ulmsc_rx_evt_t                 rx_head,
	input  wire logic                     rx_head_break,
	output logic                          rx_store,
	output logic                          rx_store_err,
	output logic                          rx_break_store,
	output logic                          rx_serial,
	// Transmitter side
	input  wire logic                     tx_load,
	input  wire logic                     tx_hold_empty,
	input  wire logic                     tx_shift_empty,
	input  wire logic                     tx_serial,
	input  wire logic                     ir_pulse_win,
	output logic                          tx_resume,
	output logic                          tx_go,
	output logic [5:0]                    rts_hyst_chars,
	// Pins
	input  wire logic                     rxd,
	input  wire logic                     ir_rxd,
	input  wire logic                     cts_n,
	input  wire logic                     dsr_n,
	input  wire logic                     ri_n,
	input  wire logic                     cd_n,
	output logic                          txd,
	output logic                          ir_txd,
	output logic                          rts_n,
	output logic                          dtr_n,
	// Interrupt requests
	output logic                          line_irq,
	output logic                          modem_irq
);
	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

	// Refuse sizes the counters cannot serve
	if (FRAME_BITS < 2 || FRAME_BITS > 255) begin : g_bad_frame
		$error("FRAME_BITS out of range");
	end
	if (FIFO_DEPTH < 1 || FIFO_DEPTH > 4096) begin : g_bad_depth
		$error("FIFO_DEPTH out of range");
	end

	// Hysteresis table lookup
	function automatic logic [5:0] hyst_lookup(input logic [3:0] code);
		logic [5:0] r;
		r = 6'h00;
		unique case (code)
			4'h0: r = 6'h00;
			4'h1: r = 6'h04;
			4'h2: r = 6'h06;
			4'h3: r = 6'h08;
			4'h4: r = 6'h08;
			4'h5: r = 6'h10;
			4'h6: r = 6'h18;
			4'h7: r = 6'h20;
			4'h8: r = 6'h28;
			4'h9: r = 6'h2c;
			4'ha: r = 6'h30;
			4'hb: r = 6'h34;
			4'hc: r = 6'h0c;
			4'hd: r = 6'h14;
			4'he: r = 6'h1c;
			4'hf: r = 6'h24;
		endcase
		return r;
	endfunction

	// Register state
	logic [7:0]       mcr_reg;
	logic [7:0]       shr_reg;
	logic             overrun_reg;
	logic [3:0]       delta_reg;
	ulmsc_modem_t     modem_prev_reg;
	logic [CNT_W-1:0] err_cnt_reg;
	logic [1:0]       pre_cnt_reg;
	logic [7:0]       brk_cnt_reg;
	logic             brk_seen_reg;

	// Three-stage pin synchronisers with agreement filter
	localparam int NPIN = 6;
	logic [NPIN-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
	wire  [NPIN-1:0] pin_raw = {ir_rxd, rxd, cd_n, ri_n, dsr_n, cts_n};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_s1_reg <= {NPIN{1'b1}};
			pin_s2_reg <= {NPIN{1'b1}};
			pin_s3_reg <= {NPIN{1'b1}};
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	// Each filtered pin follows only when stages two and three agree
	genvar gi;
	for (gi = 0; gi < NPIN; gi++) begin : g_filt
		always_ff @(posedge core_clk) begin
			if (rst)
				pin_reg[gi] <= 1'b1;
			else if (pin_s2_reg[gi] == pin_s3_reg[gi])
				pin_reg[gi] <= pin_s3_reg[gi];
		end
	end

	// Host access decode
	wire wr_mcr = host_wr && (host_addr == `ULMSC_OFF_MODEM_CTRL);
	wire wr_shr = host_wr && (host_addr == `ULMSC_OFF_RS485_SETUP);
	wire rd_lsr = host_rd && (host_addr == `ULMSC_OFF_LINE_STATUS);
	wire rd_msr = host_rd && (host_addr == `ULMSC_OFF_MODEM_STATUS);

	// Upper control bits pass only with enhanced functions on
	wire [7:0] mcr_mask = enh_func_en ? 8'hff : ~`ULMSC_MCR_ENH_MASK;
	wire [7:0] mcr_next = (host_wdata & mcr_mask) | (mcr_reg & ~mcr_mask);

	// Modem input levels, from pins or from control bits in loopback
	ulmsc_modem_t modem_pin, modem_now;
	assign modem_pin = '{cd: ~pin_reg[3], ri: ~pin_reg[2], dsr: ~pin_reg[1], cts: ~pin_reg[0]};
	assign modem_now = loopback_en ?
		ulmsc_modem_t'{cd: mcr_reg[`ULMSC_MCR_OP2], ri: mcr_reg[`ULMSC_MCR_OP1],
		  dsr: mcr_reg[`ULMSC_MCR_DTR], cts: mcr_reg[`ULMSC_MCR_RTS]} : modem_pin;

	// Change detection; ring counts only on the trailing edge of ringing
	wire [3:0] delta_set = {modem_now.cd ^ modem_prev_reg.cd,
	                        modem_prev_reg.ri & ~modem_now.ri,
	                        modem_now.dsr ^ modem_prev_reg.dsr,
	                        modem_now.cts ^ modem_prev_reg.cts};
	wire [3:0] delta_next = delta_set | (rd_msr ? 4'h0 : delta_reg);

	// Receive routing through the infrared decoder
	wire ir_en     = mcr_reg[`ULMSC_MCR_IR_EN];
	wire rx_line   = ir_en ? ~pin_reg[5] : pin_reg[4];

	// Receive character disposition
	wire flow_drop = sw_flow_en && rx_evt.flow_char;
	wire overrun   = rx_evt.valid && rx_fifo_full;
	wire store     = rx_evt.valid && !rx_fifo_full && !flow_drop;
	wire store_err = store && (rx_evt.parity_err || rx_evt.frame_err);
	wire resume    = rx_evt.valid && mcr_reg[`ULMSC_MCR_XON_ANY];

	// Break detection over one full frame of low line
	wire brk_hit   = !rx_line && bit_tick && !brk_seen_reg &&
	                 (brk_cnt_reg == 8'(FRAME_BITS - 1));
	wire brk_push  = brk_hit && !rx_fifo_full;

	// Count of error-tagged characters in the receive FIFO
	wire add_err   = store_err || brk_push;
	wire sub_err   = rx_pop && rx_pop_err;
	wire [CNT_W-1:0] err_cnt_next = err_cnt_reg + CNT_W'(add_err) - CNT_W'(sub_err);

	// Line status assembly
	wire head_ok   = rx_fifo_nonempty;
	wire [7:0] lsr_now = {
		(err_cnt_reg != '0),
		tx_hold_empty && tx_shift_empty && !tx_load,
		tx_hold_empty && !tx_load,
		head_ok && rx_head_break,
		head_ok && rx_head.frame_err,
		head_ok && rx_head.parity_err,
		overrun_reg,
		rx_fifo_nonempty};
	wire [7:0] msr_now = {modem_now.cd, modem_now.ri, modem_now.dsr, modem_now.cts, delta_reg};

	// Read data selection; the setup register is write-only
	wire [7:0] rdata_next =
		(host_addr == `ULMSC_OFF_MODEM_CTRL)   ? mcr_reg :
		(host_addr == `ULMSC_OFF_LINE_STATUS)  ? lsr_now :
		(host_addr == `ULMSC_OFF_MODEM_STATUS) ? msr_now : 8'h00;

	// Interrupt conditions: overrun at once, errors at the holding register
	wire line_irq_next  = line_int_en && (overrun_reg || overrun ||
	                      lsr_now[2] || lsr_now[3] || lsr_now[4]);
	wire modem_irq_next = modem_int_en && (delta_next != 4'h0);

	// Prescaler: every cycle or every fourth cycle
	wire prescale_tick = mcr_reg[`ULMSC_MCR_PRESCALE] ?
	                     (pre_cnt_reg == 2'(`ULMSC_PRESCALE_DIV - 3'h1)) : 1'b1;

	// RS-485 direction sequencer
	logic rs485_rts, rs485_go;
	ulmsc_rs485 u_rs485 (
		.core_clk   (core_clk),
		.rst        (rst),
		.enable     (rs485_auto_en),
		.bit_tick   (bit_tick),
		.setup_bits (shr_reg[7:4]),
		.hold_bits  (shr_reg[3:0]),
		.tx_pending (!tx_hold_empty),
		.tx_busy    (!tx_shift_empty),
		.rts_active (rs485_rts),
		.tx_go      (rs485_go)
	);

	// Control registers and sticky flags; a set beats a read clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mcr_reg        <= `ULMSC_MCR_RESET;
			shr_reg        <= `ULMSC_SHR_RESET;
			overrun_reg    <= 1'b0;
			delta_reg      <= 4'h0;
			modem_prev_reg <= '0;
			err_cnt_reg    <= '0;
		end else begin
			if (wr_mcr)
				mcr_reg <= mcr_next;
			if (wr_shr)
				shr_reg <= host_wdata;
			overrun_reg    <= overrun || (overrun_reg && !rd_lsr);
			delta_reg      <= delta_next;
			modem_prev_reg <= modem_now;
			err_cnt_reg    <= err_cnt_next;
		end
	end

	// Break counter: counts low bit times, one entry until the line goes high
	always_ff @(posedge core_clk) begin
		if (rst) begin
			brk_cnt_reg  <= 8'h00;
			brk_seen_reg <= 1'b0;
		end else if (rx_line) begin
			brk_cnt_reg  <= 8'h00;
			brk_seen_reg <= 1'b0;
		end else if (bit_tick && !brk_seen_reg) begin
			brk_cnt_reg  <= brk_hit ? 8'h00 : brk_cnt_reg + 8'h01;
			brk_seen_reg <= brk_hit;
		end
	end

	// Prescaler counter
	always_ff @(posedge core_clk) begin
		if (rst)
			pre_cnt_reg <= 2'h0;
		else
			pre_cnt_reg <= pre_cnt_reg + 2'h1;
	end

	// Registered outputs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			host_rdata     <= 8'h00;
			baud_clk_tick  <= 1'b0;
			rx_store       <= 1'b0;
			rx_store_err   <= 1'b0;
			rx_break_store <= 1'b0;
			rx_serial      <= 1'b1;
			tx_resume      <= 1'b0;
			tx_go          <= 1'b0;
			rts_hyst_chars <= 6'h00;
			txd            <= 1'b1;
			ir_txd         <= 1'b0;
			rts_n          <= 1'b1;
			dtr_n          <= 1'b1;
			line_irq       <= 1'b0;
			modem_irq      <= 1'b0;
		end else begin
			if (host_rd)
				host_rdata <= rdata_next;
			baud_clk_tick  <= prescale_tick;
			rx_store       <= store;
			rx_store_err   <= store_err;
			rx_break_store <= brk_push;
			rx_serial      <= rx_line;
			tx_resume      <= resume;
			tx_go          <= rs485_auto_en ? rs485_go : 1'b1;
			rts_hyst_chars <= (auto_rts_en && prog_trig_en) ?
			                  hyst_lookup(shr_reg[3:0]) : 6'h00;
			txd            <= ir_en ? 1'b1 : tx_serial;
			ir_txd         <= ir_en && !tx_serial && ir_pulse_win;
			rts_n          <= rs485_auto_en ? !rs485_rts : !mcr_reg[`ULMSC_MCR_RTS];
			dtr_n          <= !mcr_reg[`ULMSC_MCR_DTR];
			line_irq       <= line_irq_next;
			modem_irq      <= modem_irq_next;
		end
	end
endmodule

// *** verif/tb_uart_line_modem_status_ctrl.sv ***
// Self-checking bench for the line/modem status block
`timescale 1ns/100ps
`include "ulmsc_consts.svh"
module tb_uart_line_modem_status_ctrl import ulmsc_pkg::*;;
	logic          core_clk = 0, rst = 1, host_wr = 0, host_rd = 0, enh_func_en = 0, loopback_en = 0;
	logic          sw_flow_en = 0, rs485_auto_en = 0, auto_rts_en = 0, prog_trig_en = 0, line_int_en = 0;
	logic          modem_int_en = 0, bit_tick = 0, rx_fifo_full = 0, rx_fifo_nonempty = 0, rx_pop = 0;
	logic          rx_pop_err = 0, rx_head_break = 0, tx_load = 0, tx_hold_empty = 1, tx_shift_empty = 1;
	logic          tx_serial = 1, ir_pulse_win = 0, ir_rxd = 1, line_low = 0, seen = 0;
	logic [2:0]    host_addr = 0;
	logic [7:0]    host_wdata = 0;
	logic [1:0]    tick_cnt = 0;
	logic [31:0]   seed = 32'h0001014b;
	ulmsc_rx_evt_t rx_evt = '0, rx_head = '0;
	ulmsc_modem_t  want = '0;
	wire  [7:0]    host_rdata;
	wire  [5:0]    rts_hyst_chars;
	wire           baud_clk_tick, rx_store, rx_store_err, rx_break_store, rx_serial, tx_resume, tx_go;
	wire           rxd, cts_n, dsr_n, ri_n, cd_n, txd, ir_txd, rts_n, dtr_n, line_irq, modem_irq;
	int            num_errors = 0, tests_run = 0;

	// Design and remote line partner
	ulmsc_top i_dut (.core_clk, .rst, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata, .enh_func_en,
		.loopback_en, .sw_flow_en, .rs485_auto_en, .auto_rts_en, .prog_trig_en, .line_int_en, .modem_int_en,
		.bit_tick, .baud_clk_tick, .rx_evt, .rx_fifo_full, .rx_fifo_nonempty, .rx_pop, .rx_pop_err, .rx_head,
		.rx_head_break, .rx_store, .rx_store_err, .rx_break_store, .rx_serial, .tx_load, .tx_hold_empty,
		.tx_shift_empty, .tx_serial, .ir_pulse_win, .tx_resume, .tx_go, .rts_hyst_chars, .rxd, .ir_rxd,
		.cts_n, .dsr_n, .ri_n, .cd_n, .txd, .ir_txd, .rts_n, .dtr_n, .line_irq, .modem_irq);
	ulmsc_remote i_remote (.want, .line_low, .rxd, .cts_n, .dsr_n, .ri_n, .cd_n);

	// 50 MHz clock
	always #10 core_clk = ~core_clk;

	// Advance one cycle; bit tick pulses every fourth cycle
	task automatic step();
		@(posedge core_clk);
		seen = bit_tick;
		#1;
		tick_cnt++;
		bit_tick = (tick_cnt == 2'h0);
	endtask

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [5:0] hyst(input logic [3:0] c);
		logic [5:0] t [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
			6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24};
		return t[c];
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Host register write and read, one-cycle strobes
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		host_addr = a;
		host_wdata = d;
		host_wr = 1;
		step();
		host_wr = 0;
		step();
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		host_addr = a;
		host_rd = 1;
		step();
		host_rd = 0;
		step();
		d = host_rdata;
	endtask

	task automatic results();
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// A wait that ran out of cycles ends the run
	task automatic guard(input int i);
		if (i >= 200) begin
			num_errors++;
			results();
		end
	endtask

	initial begin
		logic [7:0]  d, e, m, ec;
		logic [31:0] r;
		logic [7:0]  sh [2];
		int          i, k, n;
		sh = '{8'h32, 8'h0f};
		m = 8'h00;
		ec = 8'h00;
		repeat (10) step();
		rst = 0;
		// Reset values, unmapped and write-only places
		rd(`ULMSC_OFF_MODEM_CTRL, d);
		chk(d, `ULMSC_MCR_RESET);
		rd(3'h0, d);
		chk(d, 8'h00);
		rd(`ULMSC_OFF_RS485_SETUP, d);
		chk(d, 8'h00);
		// Upper control bits follow the enhanced enable
		for (i = 0; i < 6; i++) begin
			enh_func_en = i[0];
			d = xs() & 8'hef;
			wr(`ULMSC_OFF_MODEM_CTRL, d);
			e = enh_func_en ? d : {m[7:5], d[4:0]};
			rd(`ULMSC_OFF_MODEM_CTRL, m);
			chk(m, e);
			chk({7'h0, dtr_n}, {7'h0, ~e[0]});
		end
		// Prescaler: every cycle, then one in four
		enh_func_en = 1;
		for (i = 0; i < 2; i++) begin
			wr(`ULMSC_OFF_MODEM_CTRL, {i[0], 7'h00});
			n = 0;
			repeat (40) begin
				step();
				n += (baud_clk_tick === 1'b1);
			end
			chk(n[7:0], i ? 8'h0a : 8'h28);
		end
		// Hysteresis code table
		auto_rts_en = 1;
		prog_trig_en = 1;
		for (i = 0; i < 16; i++) begin
			wr(`ULMSC_OFF_RS485_SETUP, {4'h0, i[3:0]});
			step();
			chk({2'h0, rts_hyst_chars}, {2'h0, hyst(i[3:0])});
		end
		// Direction setup and turn-around delays in bit ticks
		rs485_auto_en = 1;
		for (k = 0; k < 2; k++) begin
			wr(`ULMSC_OFF_RS485_SETUP, sh[k]);
			for (i = 0; i < 4 && tick_cnt != 2'h1; i++) step();
			tx_hold_empty = 0;
			tx_shift_empty = 0;
			n = 0;
			for (i = 0; i < 200; i++) begin
				step();
				n += seen;
				if (tx_go === 1'b1) break;
			end
			guard(i);
			chk(n[7:0], {4'h0, sh[k][7:4]});
			chk({7'h0, rts_n}, 8'h00);
			for (i = 0; i < 4 && tick_cnt != 2'h1; i++) step();
			tx_hold_empty = 1;
			tx_shift_empty = 1;
			n = 0;
			for (i = 0; i < 200; i++) begin
				step();
				n += seen;
				if (rts_n === 1'b1) break;
			end
			guard(i);
			chk(n[7:0], {4'h0, sh[k][3:0]});
		end
		rs485_auto_en = 0;
		// Random receive events with resume-on-any enabled
		wr(`ULMSC_OFF_MODEM_CTRL, 8'h20);
		line_int_en = 1;
		for (i = 0; i < 40; i++) begin
			r = xs();
			sw_flow_en = r[0];
			rx_fifo_full = r[1] & r[2];
			rx_evt = {1'b1, r[5:3]};
			rx_head = r[9:6];
			rx_head_break = r[10];
			rx_pop = r[11];
			rx_pop_err = r[12] && (ec != 8'h00);
			tx_load = r[13];
			ir_pulse_win = r[14];
			e = {7'h0, ~rx_fifo_full & ~(sw_flow_en & r[5])};
			step();
			chk({7'h0, rx_store}, e);
			chk({7'h0, rx_store_err}, e & {7'h0, r[4] | r[3]});
			chk({7'h0, tx_resume}, 8'h01);
			ec = ec + 8'(e[0] & (r[4] | r[3])) - 8'(rx_pop & rx_pop_err);
			rx_evt = '0;
			rx_pop = 0;
			step();
		end
		{rx_pop, rx_pop_err, tx_load, ir_pulse_win} = '0;
		// Overrun and head-character flags in line status
		rx_fifo_full = 1;
		rx_fifo_nonempty = 1;
		rx_head = 4'b1010;
		rx_head_break = 0;
		tx_shift_empty = 0;
		rx_evt = 4'b1000;
		step();
		rx_evt = '0;
		repeat (3) step();
		chk({7'h0, line_irq}, 8'h01);
		rd(`ULMSC_OFF_LINE_STATUS, d);
		chk(d & 8'h7f, 8'h27);
		chk({7'h0, d[7]}, {7'h0, ec != 8'h00});
		rd(`ULMSC_OFF_LINE_STATUS, d);
		chk(d & 8'h7f, 8'h25);
		rx_head = 4'b1001;
		rx_head_break = 1;
		tx_shift_empty = 1;
		step();
		rd(`ULMSC_OFF_LINE_STATUS, d);
		chk(d & 8'h7f, 8'h79);
		rx_fifo_nonempty = 0;
		rd(`ULMSC_OFF_LINE_STATUS, d);
		chk(d & 8'h7f, 8'h60);
		rx_head_break = 0;
		rx_fifo_full = 0;
		// Modem levels, change flags and interrupt
		modem_int_en = 1;
		rd(`ULMSC_OFF_MODEM_STATUS, d);
		want = 4'b1111;
		repeat (8) step();
		chk({7'h0, modem_irq}, 8'h01);
		rd(`ULMSC_OFF_MODEM_STATUS, d);
		chk(d, 8'hfb);
		rd(`ULMSC_OFF_MODEM_STATUS, d);
		chk(d, 8'hf0);
		chk({7'h0, modem_irq}, 8'h00);
		want = 4'b1011;
		repeat (8) step();
		rd(`ULMSC_OFF_MODEM_STATUS, d);
		chk(d, 8'hb4);
		loopback_en = 1;
		step();
		rd(`ULMSC_OFF_MODEM_STATUS, d);
		chk(d, 8'h0b);
		loopback_en = 0;
		// Break held for well over one frame
		line_low = 1;
		n = 0;
		repeat (100) begin
			step();
			n += (rx_break_store === 1'b1);
		end
		chk(n[7:0], 8'h01);
		line_low = 0;
		repeat (8) step();
		// Infrared routing and idle levels
		wr(`ULMSC_OFF_MODEM_CTRL, 8'h40);
		ir_rxd = 0;
		repeat (8) step();
		chk({6'h0, txd, ir_txd}, 8'h02);
		chk({7'h0, rx_serial}, 8'h01);
		ir_rxd = 1;
		tx_serial = 0;
		ir_pulse_win = 1;
		repeat (8) step();
		chk({6'h0, rx_serial, ir_txd}, 8'h01);
		results();
	end
endmodule

// *** verif/ulmsc_assertions.sv ***
// Port-level assertions for the line/modem status block
`timescale 1ns/100ps
module ulmsc_assertions import ulmsc_pkg::*; (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// Host and configuration
	input wire logic       host_rd,
	input wire logic [7:0] host_rdata,
	input wire logic       sw_flow_en,
	input wire logic       rs485_auto_en,
	input wire logic       line_int_en,
	input wire logic       modem_int_en,
	// Receiver and transmitter
	input ulmsc_rx_evt_t   rx_evt,
	input wire logic       rx_fifo_full,
	input wire logic       rx_store,
	input wire logic       rx_break_store,
	input wire logic       tx_hold_empty,
	input wire logic       tx_serial,
	input wire logic       tx_resume,
	input wire logic       tx_go,
	// Pins and interrupts
	input wire logic       ir_txd,
	input wire logic       rts_n,
	input wire logic       line_irq,
	input wire logic       modem_irq
);
	// One clock domain, reset disables every check
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Receive characters, flow characters and overrun
	a_store_on_evt: assert property (rx_evt.valid && !rx_fifo_full && !(sw_flow_en && rx_evt.flow_char) |=> rx_store)
		else $error("received character not stored");
	a_full_no_store: assert property (rx_evt.valid && rx_fifo_full |=> !rx_store)
		else $error("character stored into a full fifo");
	a_flow_dropped: assert property (rx_evt.valid && sw_flow_en && rx_evt.flow_char |=> !rx_store)
		else $error("flow character stored");
	a_resume_cause: assert property (tx_resume |-> $past(rx_evt.valid))
		else $error("resume without a received character");
	a_overrun_irq: assert property (rx_evt.valid && rx_fifo_full && line_int_en |-> ##[1:3] line_irq)
		else $error("overrun raised no line interrupt");
	a_break_single: assert property (rx_break_store |=> !rx_break_store [*8])
		else $error("break stored more than once");
	// Direction control and idle levels
	a_rs485_rts: assert property (rs485_auto_en && !tx_hold_empty ##1 rs485_auto_en |=> !rts_n)
		else $error("direction output not asserted for pending data");
	a_go_plain: assert property (!rs485_auto_en |=> tx_go)
		else $error("transmit held outside direction mode");
	a_ir_idle_low: assert property (tx_serial |=> !ir_txd)
		else $error("infrared output high on idle line");
	// Status reads and modem interrupt
	a_rdata_held: assert property (!host_rd |=> $stable(host_rdata))
		else $error("read data changed without a read");
	a_modem_irq_gate: assert property (!modem_int_en |=> !modem_irq)
		else $error("modem interrupt while disabled");
endmodule

bind ulmsc_top ulmsc_assertions i_chk (.core_clk, .rst, .host_rd, .host_rdata, .sw_flow_en, .rs485_auto_en,
	.line_int_en, .modem_int_en, .rx_evt, .rx_fifo_full, .rx_store, .rx_break_store, .tx_hold_empty,
	.tx_serial, .tx_resume, .tx_go, .ir_txd, .rts_n, .line_irq, .modem_irq);

// *** verif/ulmsc_remote.sv ***
// Remote modem and serial line driving the block's pins
`timescale 1ns/100ps
module ulmsc_remote import ulmsc_pkg::*; (
	// Commanded levels, active high
	input ulmsc_modem_t want,
	input wire logic    line_low,
	// Pins toward the block
	output logic        rxd,
	output logic        cts_n,
	output logic        dsr_n,
	output logic        ri_n,
	output logic        cd_n
);
	// Modem lines are active low at the pins
	assign {cd_n, ri_n, dsr_n, cts_n} = ~want;
	// Line idles at mark; a break holds it at space
	assign rxd = ~line_low;
endmodule
